/* inc/pmc_pkg.sv */
package pmc_pkg;
  typedef logic [15:0] pmc_word_t;
  typedef logic [7:0]  pmc_byte_t;

  localparam pmc_byte_t PTR_CFG  = 8'h00;
  localparam pmc_byte_t PTR_STAT = 8'h01;
  localparam pmc_byte_t PTR_BLW  = 8'h10;
  localparam pmc_byte_t PTR_POL  = 8'h11;
  localparam pmc_byte_t PTR_BHO  = 8'h12;
  localparam pmc_byte_t PTR_BLO  = 8'h13;
  localparam pmc_byte_t PTR_CRP  = 8'h14;
  localparam pmc_byte_t PTR_CRN  = 8'h15;
  localparam pmc_byte_t PTR_CAL  = 8'h16;

  localparam pmc_word_t CFG_RST  = 16'h399f;
  localparam pmc_word_t CFG_MASK = 16'h3fff;
  localparam pmc_word_t LIM_RST  = 16'h0000;

  localparam int CFG_SWRST = 15;
  localparam int CFG_BUS_RANGE_SELECT  = 13;
  localparam int CFG_PG_HI = 12;
  localparam int CFG_PG_LO = 11;
  localparam int CFG_BUS_CONV_SETTING  = 7;
  localparam int CFG_SHUNT_CONV_SETTING  = 3;
  localparam int BHO_POL   = 1;
  localparam int BHO_LATCH = 0;
  localparam int CRP_LATCH = 0;
  localparam int BUS_LSB   = 3;
  localparam int FLG_LSB   = 3;
  localparam int FLG_CONVERSION_DONE_FLAG  = 5;

  localparam logic [2:0] MODE_PDOWN = 3'h0;
  localparam logic [2:0] MODE_OFF   = 3'h4;

  localparam int COMMIT_NS  = 4000;
  localparam int CLK_NS     = 100;
  localparam int COMMIT_CYC = (COMMIT_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_WR_LO = 3'b010,
    ST_RD_LO = 3'b100
  } pmc_state_t;
endpackage

/* inc/pmc_commit_if.sv */
`timescale 1ns/1ps
interface pmc_commit_if;
  logic start;
  logic busy;
  logic fire;
  modport ctl (output start, input busy, input fire);
  modport tmr (input start, output busy, output fire);
endinterface

/* src/pmc_commit_timer.sv */
`timescale 1ns/1ps
module pmc_commit_timer #(
  parameter int unsigned CYCLES = pmc_pkg::COMMIT_CYC
) (
  input wire logic   ref_clk,
  input wire logic   rstn,
  pmc_commit_if.tmr  ci
);
  import pmc_pkg::*;
  logic [15:0] cnt;
  logic [15:0] age;

  // a new start restarts the wait; the caller commits the older write first
  always_ff @(posedge ref_clk) begin
    if (!rstn)
      cnt <= 16'h0000;
    else if (ci.start)
      cnt <= 16'(CYCLES);
    else if (cnt != 16'h0000)
      cnt <= cnt - 16'h0001;
  end

  assign ci.busy = (cnt != 16'h0000);
  assign ci.fire = (cnt == 16'h0001);

  always_ff @(posedge ref_clk) begin
    if (!rstn || ci.start)
      age <= 16'h0001;
    else if (age != 16'hffff)
      age <= age + 16'h0001;
  end

  property p_fire_time;
    @(posedge ref_clk) disable iff (!rstn)
    ci.fire |-> age == 16'(CYCLES);
  endproperty
  a_fire_time: assert property (p_fire_time) else $error("commit delay wrong");
endmodule

/* src/pmc_regbank.sv */
`timescale 1ns/1ps
module pmc_regbank (
  input  wire logic          ref_clk,
  input  wire logic          rstn,
  input  wire logic          ptr_load,
  input  pmc_pkg::pmc_byte_t ptr_byte,
  input  wire logic          wr_stb,
  input  pmc_pkg::pmc_byte_t wr_byte,
  input  wire logic          rd_stb,
  output pmc_pkg::pmc_byte_t rd_byte,
  output logic               rd_valid,
  input  pmc_pkg::pmc_word_t bus_voltage,
  input  pmc_pkg::pmc_word_t power_value,
  input  wire logic          warn_bus_high_hit,
  input  wire logic          warn_power_hit,
  input  wire logic          warn_shunt_pos_hit,
  input  wire logic          warn_shunt_neg_hit,
  input  wire logic          warn_latch,
  input  wire logic          warn_active_high,
  input  wire logic          critical_pos_flag_pos_hit,
  input  wire logic          critical_pos_flag_neg_hit,
  input  wire logic          conv_done,
  input  wire logic          convert_trig,
  input  wire logic          alert_hit,
  input  wire logic          math_ovf,
  output logic               warn_out,
  output logic               overlimit_out,
  output logic               bus_range_select,
  output logic               shunt_gain_hi,
  output logic               shunt_gain_lo,
  output logic [3:0]         bus_conv_setting,
  output logic [3:0]         shunt_conv_setting,
  output logic [2:0]         op_mode,
  output logic [1:0]         bus_res_code,
  output logic [2:0]         bus_avg_log2,
  output logic [1:0]         shunt_res_code,
  output logic [2:0]         shunt_avg_log2,
  output pmc_pkg::pmc_word_t critical_pos_flag_pos_thresh,
  output pmc_pkg::pmc_word_t critical_pos_flag_neg_thresh,
  output pmc_pkg::pmc_word_t scale_cal
);
  import pmc_pkg::*;

  pmc_state_t  st;
  pmc_byte_t   ptr;
  pmc_byte_t   wr_hi;
  pmc_byte_t   rd_lo;
  pmc_byte_t   pend_ptr;
  pmc_word_t   pend_data;
  pmc_word_t   rd_data;
  pmc_word_t   cfg;
  pmc_word_t   blw;
  pmc_word_t   pol;
  pmc_word_t   bho;
  pmc_word_t   blo;
  pmc_word_t   crp;
  pmc_word_t   crn;
  pmc_word_t   cal;
  logic [15:3] flags;
  logic [15:3] hit;
  logic [15:3] lat;
  logic [15:3] clr;
  logic [15:3] next_flags;
  logic        wr_done;
  logic        commit;
  logic        sreset;
  logic        stat_rd;
  logic        conversion_done_flag_clr;
  logic        pend_vld;

  pmc_commit_if ci ();

  pmc_commit_timer #(.CYCLES(COMMIT_CYC)) u_timer (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .ci      (ci.tmr)
  );

  // field code -> {resolution code, log2 of averaged samples}
  function automatic logic [4:0] adc_decode(input logic [3:0] code);
    if (!code[3])
      adc_decode = {code[1:0], 3'h0};
    else
      adc_decode = {2'h3, code[2:0]};
  endfunction

  assign wr_done  = wr_stb && !ptr_load && (st == ST_WR_LO);
  assign ci.start = wr_done;
  // a back-to-back write pushes the older pending value in early rather than losing it
  assign commit   = pend_vld && (ci.fire || (wr_done && ci.busy));
  assign sreset   = commit && (pend_ptr == PTR_CFG) && pend_data[CFG_SWRST];
  assign stat_rd  = rd_stb && !ptr_load && (st == ST_IDLE) && (ptr == PTR_STAT);
  assign conversion_done_flag_clr = convert_trig || (commit && (pend_ptr == PTR_CFG) &&
                    (pend_data[2:0] != MODE_PDOWN) && (pend_data[2:0] != MODE_OFF));

  // byte phase tracking; a pointer load always restarts at the high byte
  always_ff @(posedge ref_clk) begin
    if (!rstn || sreset) begin
      st  <= ST_IDLE;
      ptr <= PTR_CFG;
    end else if (ptr_load) begin
      st  <= ST_IDLE;
      ptr <= ptr_byte;
    end else begin
      case (st)
        ST_IDLE: begin
          if (wr_stb)
            st <= ST_WR_LO;
          else if (rd_stb)
            st <= ST_RD_LO;
        end
        ST_WR_LO: begin
          if (wr_stb)
            st <= ST_IDLE;
        end
        ST_RD_LO: begin
          if (rd_stb)
            st <= ST_IDLE;
        end
        default: st <= ST_IDLE;
      endcase
    end
  end

  always_comb begin
    case (ptr)
      PTR_CFG:  rd_data = cfg;
      PTR_STAT: rd_data = {flags, 3'h0};
      PTR_BLW:  rd_data = blw;
      PTR_POL:  rd_data = pol;
      PTR_BHO:  rd_data = bho;
      PTR_BLO:  rd_data = blo;
      PTR_CRP:  rd_data = crp;
      PTR_CRN:  rd_data = crn;
      PTR_CAL:  rd_data = cal;
      default:  rd_data = 16'h0000;
    endcase
  end

  // low byte is snapshotted with the high one so the pair stays coherent
  always_ff @(posedge ref_clk) begin
    if (!rstn || sreset) begin
      rd_byte  <= 8'h00;
      rd_lo    <= 8'h00;
      rd_valid <= 1'b0;
      wr_hi    <= 8'h00;
    end else begin
      rd_valid <= 1'b0;
      if (wr_stb && !ptr_load && st == ST_IDLE)
        wr_hi <= wr_byte;
      if (rd_stb && !ptr_load && st == ST_IDLE) begin
        rd_byte  <= rd_data[15:8];
        rd_lo    <= rd_data[7:0];
        rd_valid <= 1'b1;
      end else if (rd_stb && !ptr_load && st == ST_RD_LO) begin
        rd_byte  <= rd_lo;
        rd_valid <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn || sreset) begin
      pend_ptr  <= PTR_CFG;
      pend_data <= 16'h0000;
    end else if (wr_done) begin
      pend_ptr  <= ptr;
      pend_data <= {wr_hi, wr_byte};
    end
  end

  // a write dropped by a soft reset must not commit when its timer later runs out
  always_ff @(posedge ref_clk) begin
    if (!rstn || sreset)
      pend_vld <= 1'b0;
    else if (wr_done)
      pend_vld <= 1'b1;
    else if (commit)
      pend_vld <= 1'b0;
  end

  // reads see the old value until the commit delay has run out or a back-to-back write pushes it in early
  always_ff @(posedge ref_clk) begin
    if (!rstn || sreset) begin
      cfg <= CFG_RST;
      blw <= LIM_RST;
      pol <= LIM_RST;
      bho <= LIM_RST;
      blo <= LIM_RST;
      crp <= LIM_RST;
      crn <= LIM_RST;
      cal <= LIM_RST;
    end else if (commit) begin
      case (pend_ptr)
        PTR_CFG: cfg <= pend_data & CFG_MASK;
        PTR_BLW: blw <= pend_data;
        PTR_POL: pol <= pend_data;
        PTR_BHO: bho <= pend_data;
        PTR_BLO: blo <= pend_data;
        PTR_CRP: crp <= pend_data;
        PTR_CRN: crn <= pend_data;
        PTR_CAL: cal <= pend_data;
        default: cfg <= cfg;
      endcase
    end
  end

  assign bus_range_select   = cfg[CFG_BUS_RANGE_SELECT];
  assign shunt_gain_hi      = cfg[CFG_PG_HI];
  assign shunt_gain_lo      = cfg[CFG_PG_LO];
  assign bus_conv_setting   = cfg[CFG_BUS_CONV_SETTING+3:CFG_BUS_CONV_SETTING];
  assign shunt_conv_setting = cfg[CFG_SHUNT_CONV_SETTING+3:CFG_SHUNT_CONV_SETTING];
  assign op_mode            = cfg[2:0];
  assign critical_pos_flag_pos_thresh    = crp;
  assign critical_pos_flag_neg_thresh    = crn;
  assign scale_cal          = cal;

  // decoded settings lag the field by one cycle
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      bus_res_code   <= 2'h0;
      bus_avg_log2   <= 3'h0;
      shunt_res_code <= 2'h0;
      shunt_avg_log2 <= 3'h0;
    end else begin
      {bus_res_code, bus_avg_log2}     <= adc_decode(cfg[CFG_BUS_CONV_SETTING+3:CFG_BUS_CONV_SETTING]);
      {shunt_res_code, shunt_avg_log2} <= adc_decode(cfg[CFG_SHUNT_CONV_SETTING+3:CFG_SHUNT_CONV_SETTING]);
    end
  end

  always_comb begin
    hit     = 13'h0000;
    hit[15] = warn_bus_high_hit;
    hit[14] = bus_voltage[15:BUS_LSB] < blw[15:BUS_LSB];
    hit[13] = warn_power_hit;
    hit[12] = warn_shunt_pos_hit;
    hit[11] = warn_shunt_neg_hit;
    hit[10] = bus_voltage[15:BUS_LSB] > bho[15:BUS_LSB];
    hit[9]  = bus_voltage[15:BUS_LSB] < blo[15:BUS_LSB];
    hit[8]  = power_value > pol;
    hit[7]  = critical_pos_flag_pos_hit;
    hit[6]  = critical_pos_flag_neg_hit;
    hit[5]  = conv_done;
    hit[4]  = alert_hit;
    hit[3]  = math_ovf;
    lat     = {{5{warn_latch}}, {3{bho[BHO_LATCH]}}, {2{crp[CRP_LATCH]}}, 3'h7};
    clr     = {13{stat_rd}};
    clr[FLG_CONVERSION_DONE_FLAG] = stat_rd || conversion_done_flag_clr;
  end

  // set always beats clear so an event in the reading cycle survives
  for (genvar i = FLG_LSB; i <= 15; i++) begin : g_flag
    assign next_flags[i] = hit[i] || (flags[i] && lat[i] && !clr[i]);
  end

  // outputs use next_flags so the pins move with the flag, not a cycle later
  always_ff @(posedge ref_clk) begin
    if (!rstn || sreset) begin
      flags         <= 13'h0000;
      warn_out      <= 1'b0;
      overlimit_out <= 1'b1;
    end else begin
      flags         <= next_flags;
      warn_out      <= (|next_flags[15:11]) == warn_active_high;
      overlimit_out <= (|next_flags[10:8]) == bho[BHO_POL];
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  property p_rd_hi;
    rd_stb && !ptr_load && st == ST_IDLE && !sreset |=>
      rd_valid && rd_byte == $past(rd_data[15:8]);
  endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("high byte not first");

  property p_swrst;
    sreset |=> cfg == CFG_RST && cal == LIM_RST && flags == 13'h0000;
  endproperty
  a_swrst: assert property (p_swrst) else $error("soft reset missed");

  property p_cfg_wr;
    commit && !sreset && pend_ptr == PTR_CFG |=> cfg == ($past(pend_data) & CFG_MASK);
  endproperty
  a_cfg_wr: assert property (p_cfg_wr) else $error("config write lost");

  property p_res;
    !cfg[CFG_BUS_CONV_SETTING+3] && $stable(cfg) |=>
      bus_avg_log2 == 3'h0 && bus_res_code == $past(cfg[CFG_BUS_CONV_SETTING+1:CFG_BUS_CONV_SETTING]);
  endproperty
  a_res: assert property (p_res) else $error("resolution decode");

  property p_avg;
    cfg[CFG_SHUNT_CONV_SETTING+3] && $stable(cfg) |=>
      shunt_res_code == 2'h3 && shunt_avg_log2 == $past(cfg[CFG_SHUNT_CONV_SETTING+2:CFG_SHUNT_CONV_SETTING]);
  endproperty
  a_avg: assert property (p_avg) else $error("averaging decode");

  property p_rd_clear;
    stat_rd && !sreset |=> flags == $past(hit);
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("read clear wrong");

  property p_hit_sets;
    hit != 13'h0000 && !sreset |=> (flags & $past(hit)) == $past(hit);
  endproperty
  a_hit_sets: assert property (p_hit_sets) else $error("flag not set");

  property p_latch_hold;
    flags[9] && bho[BHO_LATCH] && !stat_rd && !commit ##1 !stat_rd |-> flags[9];
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched flag dropped");

  property p_ol_out;
    $stable(bho) |-> overlimit_out == ((|flags[10:8]) == bho[BHO_POL]);
  endproperty
  a_ol_out: assert property (p_ol_out) else $error("overlimit pin wrong");

  property p_conversion_done_flag;
    convert_trig && !conv_done && !sreset |=> !flags[FLG_CONVERSION_DONE_FLAG];
  endproperty
  a_conversion_done_flag: assert property (p_conversion_done_flag) else $error("ready flag kept");

  property p_zero_bits;
    cfg[15:14] == 2'h0;
  endproperty
  a_zero_bits: assert property (p_zero_bits) else $error("unused config bits set");

  c_stat_rd: cover property (stat_rd && flags != 13'h0000);
  c_swrst:   cover property (sreset);
  c_early:   cover property (wr_done && ci.busy);
endmodule

/* verification/pmc_host_model.sv */
`timescale 1ns/1ps
module pmc_host_model (
  input  wire logic         ref_clk,
  input  pmc_pkg::pmc_byte_t rd_byte,
  input  wire logic         rd_valid,
  output logic              ptr_load,
  output pmc_pkg::pmc_byte_t ptr_byte,
  output logic              wr_stb,
  output pmc_pkg::pmc_byte_t wr_byte,
  output logic              rd_stb,
  output logic              rd_done,
  output pmc_pkg::pmc_word_t rd_word
);
  import pmc_pkg::*;
  initial begin
    ptr_load = 1'b0;
    ptr_byte = 8'h00;
    wr_stb   = 1'b0;
    wr_byte  = 8'h00;
    rd_stb   = 1'b0;
    rd_done  = 1'b0;
    rd_word  = 16'h0000;
  end
  task automatic point(input pmc_byte_t p);
    @(posedge ref_clk);
    ptr_load <= 1'b1;
    ptr_byte <= p;
    @(posedge ref_clk);
    ptr_load <= 1'b0;
    // a released line must not keep looking valid
    ptr_byte <= ~p;
  endtask
  // high byte goes first, low byte second
  task automatic write(input pmc_byte_t p, input pmc_word_t w, input bit wait_commit);
    point(p);
    wr_stb  <= 1'b1;
    wr_byte <= w[15:8];
    @(posedge ref_clk);
    wr_byte <= w[7:0];
    @(posedge ref_clk);
    wr_stb  <= 1'b0;
    wr_byte <= ~w[7:0];
    if (wait_commit) repeat (COMMIT_CYC + 2) @(posedge ref_clk);
  endtask
  task automatic get_byte(output pmc_byte_t b);
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    repeat (4) begin
      @(posedge ref_clk);
      if (rd_valid === 1'b1) break;
    end
    b = rd_byte;
  endtask
  task automatic read(input pmc_byte_t p);
    pmc_byte_t h;
    pmc_byte_t l;
    point(p);
    get_byte(h);
    get_byte(l);
    rd_word <= {h, l};
    rd_done <= 1'b1;
    @(posedge ref_clk);
    rd_done <= 1'b0;
  endtask
endmodule

/* verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import pmc_pkg::*;
  logic       ref_clk = 1'b0;
  logic       rstn = 1'b0;
  pmc_word_t  bus_voltage = 16'h0000;
  pmc_word_t  power_value = 16'h0000;
  logic [3:0] whit = 4'h0;
  logic       warn_latch = 1'b0;
  logic       warn_active_high = 1'b1;
  logic [1:0] critical_pos_flag = 2'h0;
  logic       conv_done = 1'b0;
  logic       convert_trig = 1'b0;
  logic       alert_hit = 1'b0;
  logic       math_ovf = 1'b0;
  logic ptr_load, wr_stb, rd_stb, rd_valid, rd_done, warn_out, overlimit_out;
  logic bus_range_select, shunt_gain_hi, shunt_gain_lo;
  logic [3:0] bus_conv_setting, shunt_conv_setting;
  logic [2:0] op_mode, bus_avg_log2, shunt_avg_log2;
  logic [1:0] bus_res_code, shunt_res_code;
  pmc_byte_t  ptr_byte, wr_byte, rd_byte;
  pmc_word_t  rd_word, critical_pos_flag_pos_thresh, critical_pos_flag_neg_thresh, scale_cal, w, cw;
  pmc_word_t  lw[7];
  pmc_word_t  exp_q[$];
  pmc_byte_t  ptr_q[$];
  int         seed = 25465;
  int         n_fail = 0;
  int         cmp_count = 0;
  wire pmc_word_t cfg_outs = {2'b00, bus_range_select, shunt_gain_hi, shunt_gain_lo,
                              bus_conv_setting, shunt_conv_setting, op_mode};
  wire pmc_word_t dec_outs = {6'h00, bus_res_code, bus_avg_log2, shunt_res_code, shunt_avg_log2};
  wire pmc_word_t pins = {14'h0000, warn_out, overlimit_out};

  always #50 ref_clk = ~ref_clk;

  pmc_regbank dut (.ref_clk, .rstn, .ptr_load, .ptr_byte, .wr_stb, .wr_byte, .rd_stb,
    .rd_byte, .rd_valid, .bus_voltage, .power_value, .warn_bus_high_hit(whit[3]),
    .warn_power_hit(whit[2]), .warn_shunt_pos_hit(whit[1]), .warn_shunt_neg_hit(whit[0]),
    .warn_latch, .warn_active_high, .critical_pos_flag_pos_hit(critical_pos_flag[1]), .critical_pos_flag_neg_hit(critical_pos_flag[0]),
    .conv_done, .convert_trig, .alert_hit, .math_ovf, .warn_out, .overlimit_out,
    .bus_range_select, .shunt_gain_hi, .shunt_gain_lo, .bus_conv_setting,
    .shunt_conv_setting, .op_mode, .bus_res_code, .bus_avg_log2, .shunt_res_code,
    .shunt_avg_log2, .critical_pos_flag_pos_thresh, .critical_pos_flag_neg_thresh, .scale_cal);

  pmc_host_model host (.ref_clk, .rd_byte, .rd_valid, .ptr_load, .ptr_byte, .wr_stb,
    .wr_byte, .rd_stb, .rd_done, .rd_word);

  task automatic summarize();
    if (n_fail == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string n, input pmc_word_t e, input pmc_word_t g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rd(input pmc_byte_t p, input pmc_word_t e);
    exp_q.push_back(e);
    ptr_q.push_back(p);
    host.read(p);
  endtask
  task automatic wr(input pmc_byte_t p, input pmc_word_t v);
    host.write(p, v, 1'b1);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  function automatic logic [4:0] dec(input logic [3:0] f);
    return f[3] ? {2'h3, f[2:0]} : {f[1:0], 3'h0};
  endfunction

  always @(posedge ref_clk) begin
    if (rd_done === 1'b1 && exp_q.size() > 0) begin
      chk($sformatf("reg %h", ptr_q.pop_front()), exp_q.pop_front(), rd_word);
    end
  end

  initial begin
    tick(20000);
    n_fail++;
    summarize();
  end

  initial begin
    tick(5);
    rstn <= 1'b1;
    tick(1);
    chk("cfg pins", CFG_RST & CFG_MASK, cfg_outs);
    rd(PTR_CFG, CFG_RST);
    rd(PTR_STAT, 16'h0000);
    for (pmc_byte_t p = PTR_BLW; p <= PTR_CAL; p++) begin
      w = 16'($random(seed));
      lw[p - PTR_BLW] = w;
      rd(p, LIM_RST);
      wr(p, w);
      rd(p, w);
    end
    chk("critical_pos_flag pos", lw[4], critical_pos_flag_pos_thresh);
    chk("critical_pos_flag neg", lw[5], critical_pos_flag_neg_thresh);
    chk("cal", lw[6], scale_cal);
    rd(8'h05, 16'h0000);
    wr(8'h20, 16'hffff);
    rd(8'h20, 16'h0000);
    // soft reset must restore the config and calibration defaults and clear any latched flags
    wr(PTR_CFG, 16'h8000);
    rd(PTR_CFG, CFG_RST);
    rd(PTR_CAL, LIM_RST);
    rd(PTR_STAT, 16'h0000);
    host.write(PTR_CAL, 16'h5a5a, 1'b0);
    rd(PTR_CAL, 16'h0000);
    tick(COMMIT_CYC);
    rd(PTR_CAL, 16'h5a5a);
    for (int k = 0; k < 16; k++) begin
      cw = {2'b01, k[0], k[1:0], k[3:0], ~k[3:0], k[2:0]};
      wr(PTR_CFG, cw);
      rd(PTR_CFG, cw & CFG_MASK);
      chk("cfg pins", cw & CFG_MASK, cfg_outs);
      chk("adc", {6'h00, dec(cw[10:7]), dec(cw[6:3])}, dec_outs);
    end
    wr(PTR_POL, 16'h1000);
    wr(PTR_BHO, 16'hfffb);
    wr(PTR_BLO, 16'h0800);
    wr(PTR_BLW, 16'h0100);
    wr(PTR_CRP, 16'h0001);
    bus_voltage <= 16'h0800;
    tick(3);
    // bus low over-limit latched while limits were set up, so the discard read shows it
    rd(PTR_STAT, 16'h0200);
    bus_voltage <= 16'h0008;
    tick(3);
    // below the warning limit is also below the over-limit one
    chk("pins", 16'h0003, pins);
    rd(PTR_STAT, 16'h4200);
    bus_voltage <= 16'h0800;
    tick(3);
    rd(PTR_STAT, 16'h0200);
    power_value <= 16'h1001;
    tick(3);
    chk("pins", 16'h0001, pins);
    rd(PTR_STAT, 16'h0100);
    rd(PTR_STAT, 16'h0100);
    power_value <= 16'h1000;
    tick(3);
    chk("pins", 16'h0001, pins);
    rd(PTR_STAT, 16'h0100);
    rd(PTR_STAT, 16'h0000);
    bus_voltage <= 16'h0400;
    tick(3);
    bus_voltage <= 16'h0800;
    tick(3);
    rd(PTR_STAT, 16'h0200);
    rd(PTR_STAT, 16'h0000);
    wr(PTR_BHO, 16'hfff9);
    chk("pins", 16'h0001, pins);
    warn_latch <= 1'b1;
    whit <= 4'hf;
    critical_pos_flag <= 2'h3;
    alert_hit <= 1'b1;
    math_ovf <= 1'b1;
    tick(1);
    whit <= 4'h0;
    critical_pos_flag <= 2'h0;
    alert_hit <= 1'b0;
    math_ovf <= 1'b0;
    tick(3);
    chk("pins", 16'h0003, pins);
    rd(PTR_STAT, 16'hb8d8);
    rd(PTR_STAT, 16'h0000);
    warn_active_high <= 1'b0;
    tick(2);
    chk("pins", 16'h0003, pins);
    warn_active_high <= 1'b1;
    warn_latch <= 1'b0;
    for (int m = 0; m < 4; m++) begin
      conv_done <= 1'b1;
      tick(1);
      conv_done <= 1'b0;
      convert_trig <= (m == 1);
      tick(1);
      convert_trig <= 1'b0;
      if (m == 2) wr(PTR_CFG, 16'h399c);
      if (m == 3) wr(PTR_CFG, 16'h399f);
      rd(PTR_STAT, (m == 0 || m == 2) ? 16'h0020 : 16'h0000);
    end
    tick(5);
    summarize();
  end
endmodule
